// file: sim/tb_top.sv
// Purpose: Self-checking bench for the watchdog malfunction timer.
// Assumes: Low-frequency source used in every test but fast_source, with LF_DIV 2 to keep runs short.
// Notes: Overflow events are noted in a queue and judged by a watcher process.
`timescale 1ns/10ps
module tb_top;
  localparam logic [11:0] CTL = wmt_pkg::ADDR_CTRL_ONE;
  localparam logic [11:0] CODE = wmt_pkg::ADDR_CODE_PORT;
  logic mclk, sys_rst, stop_mode, warm_up, idle_mode, sleep_mode;
  logic low_speed_run_mode, divider_source_select, hsel, hwrite, hreadyout, hresp, rr_q;
  logic watchdog_reset_request, watchdog_interrupt_request, trap_area_active, trap_action_select;
  logic [11:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata;
  logic [7:0] c;
  logic [1:0] kind_seen;
  logic [1:0] exp_q[$];
  int error_cnt = 0, checks_done = 0, ev_cnt = 0, wid = 0;

  wmt_cpu_model cpu (.mclk(mclk), .hready(hreadyout), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  wmt_watchdog #(.LF_DIV(2)) dut (.mclk(mclk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .stop_mode(stop_mode),
    .warm_up(warm_up), .idle_mode(idle_mode), .sleep_mode(sleep_mode),
    .low_speed_run_mode(low_speed_run_mode), .divider_source_select(divider_source_select),
    .watchdog_reset_request(watchdog_reset_request),
    .watchdog_interrupt_request(watchdog_interrupt_request),
    .trap_area_active(trap_area_active), .trap_action_select(trap_action_select));

  // Clock of 100 ns period.
  initial begin
    mclk = 1'h0;
    forever #50 mclk = ~mclk;
  end

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic cmp_kind(input logic [1:0] e, input logic [1:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch event kind exp %0d got %0d", e, g);
    end
  endtask : cmp_kind

  task automatic cmp_val(input string nm, input int e, input logic [31:0] g);
    checks_done++;
    if (g !== 32'(e)) begin
      error_cnt++;
      $display("mismatch %0s exp %0d got %0d", nm, e, g);
    end
  endtask : cmp_val

  // Reset with a randomly chosen way of selecting the slow source.
  task automatic start;
    c = 8'($urandom);
    sys_rst <= 1'h1; divider_source_select <= c[0]; low_speed_run_mode <= !c[0];
    exp_q.delete();
    repeat (4) @(posedge mclk);
    sys_rst <= 1'h0;
  endtask : start

  task automatic clr; // Only the main sequence clears, never the event watcher.
    cpu.xfer(CODE, wmt_pkg::CODE_CLEAR, 1'h1);
  endtask : clr

  task automatic settle;
    repeat (2) @(posedge mclk);
    #10;
  endtask : settle

  // Notes an event and waits for it; a wait that runs out ends the run.
  task automatic ev(input logic [1:0] k, input int lo, input int hi);
    int n;
    int c0;
    exp_q.push_back(k);
    c0 = ev_cnt;
    n = 0;
    while (ev_cnt == c0 && n < hi) begin
      @(posedge mclk);
      n++;
    end
    cmp_val("event delay in window", 1, {31'h0, n >= lo && n < hi});
    if (ev_cnt == c0) tally_and_finish();
    repeat (30) @(posedge mclk);
  endtask : ev

  // Watcher: each reset request rise or interrupt pulse takes the oldest note.
  always @(posedge mclk) begin
    if (sys_rst) begin
      rr_q <= 1'h0;
      wid <= 0;
    end else begin
      rr_q <= watchdog_reset_request;
      if (watchdog_reset_request === 1'h1) wid <= wid + 1;
      if ((watchdog_reset_request === 1'h1 && rr_q !== 1'h1) ||
          watchdog_interrupt_request === 1'h1) begin
        ev_cnt <= ev_cnt + 1;
        kind_seen = watchdog_reset_request ? 2'h1 : 2'h2;
        cmp_kind(exp_q.size() ? exp_q.pop_front() : 2'h0, kind_seen);
      end
      if (watchdog_reset_request !== 1'h1 && rr_q === 1'h1) begin
        cmp_val("reset request width", 24, wid);
        wid <= 0;
      end
    end
  end

  initial begin
    sys_rst = 1'h1; stop_mode = 1'h0; warm_up = 1'h0; idle_mode = 1'h0; sleep_mode = 1'h0;
    low_speed_run_mode = 1'h0; divider_source_select = 1'h0; c = 8'h0;
    void'($urandom(32'h03CD8DCE));
    // Default reset action; the late clear shows the divider keeps its phase.
    start();
    cmp_val("trap outputs", 3, {30'h0, trap_area_active, trap_action_select});
    cpu.xfer(CTL, 8'h3F, 1'h1);
    cpu.xfer(CTL, 8'h00, 1'h0);
    repeat (500) @(posedge mclk);
    clr();
    ev(2'h1, 3000, 3800);
    $display("test reset_action done");
    // Interrupt action is periodic and cannot be turned back to reset.
    start();
    cpu.xfer(CTL, 8'h3E, 1'h1);
    clr();
    ev(2'h2, 3000, 4200);
    cpu.xfer(CTL, 8'h3F, 1'h1);
    ev(2'h2, 3900, 4200);
    ev(2'h2, 3900, 4200);
    $display("test interrupt_action done");
    // Trap area code, regular clears, then codes that must do nothing.
    start();
    cpu.xfer(CTL, 8'h0F, 1'h1);
    settle();
    cmp_val("trap area before code", 1, {31'h0, trap_area_active});
    cmp_val("trap action", 0, {31'h0, trap_action_select});
    cpu.xfer(CODE, wmt_pkg::CODE_TRAP_AREA, 1'h1);
    settle();
    cmp_val("trap area after code", 0, {31'h0, trap_area_active});
    repeat (4) begin
      repeat (2000) @(posedge mclk);
      clr();
    end
    // Mid-period, a stray clear would push the overflow out past the window.
    repeat (1500) @(posedge mclk);
    cpu.xfer(CTL + 12'h8, wmt_pkg::CODE_CLEAR, 1'h1);
    repeat (3) begin
      do c = 8'($urandom); while (c == 8'h4E || c == 8'hB1 || c == 8'hD2);
      cpu.xfer(CODE, c, 1'h1);
    end
    ev(2'h1, 1000, 2500);
    $display("test codes done");
    // Disable needs both steps in order; disabled counters stay cleared.
    start();
    cpu.xfer(CTL, 8'h3F, 1'h1);
    clr();
    cpu.xfer(CTL, 8'h37, 1'h1);
    ev(2'h1, 3000, 4200);
    cpu.xfer(CTL, 8'h3F, 1'h1);
    cpu.xfer(CODE, wmt_pkg::CODE_DISABLE, 1'h1);
    clr();
    ev(2'h1, 3000, 4200);
    clr();
    // Let the counter fill partly, so that a disable which kept it would show.
    repeat (1500) @(posedge mclk);
    cpu.xfer(CTL, 8'h37, 1'h1);
    cpu.xfer(CODE, wmt_pkg::CODE_DISABLE, 1'h1);
    repeat (6000) @(posedge mclk);
    cpu.xfer(CTL, 8'h3F, 1'h1);
    ev(2'h1, 3000, 4200);
    $display("test disable done");
    // Stop with clears around it, then a freeze that must keep the count.
    start();
    cpu.xfer(CTL, 8'h3F, 1'h1);
    clr();
    stop_mode <= 1'h1;
    repeat (4500) @(posedge mclk);
    stop_mode <= 1'h0; warm_up <= 1'h1;
    repeat (1000) @(posedge mclk);
    warm_up <= 1'h0;
    clr();
    repeat (2600) @(posedge mclk);
    c = 8'($urandom);
    idle_mode <= c[0]; sleep_mode <= !c[0];
    repeat (4000) @(posedge mclk);
    idle_mode <= 1'h0; sleep_mode <= 1'h0;
    ev(2'h1, 0, 2000);
    $display("test freeze done");
    // The fast source needs far more cycles than this wait, so no event may come.
    divider_source_select <= 1'h0;
    low_speed_run_mode <= 1'h0;
    repeat (5000) @(posedge mclk);
    $display("test fast_source done");
    cmp_val("bus hangs", 0, 32'(cpu.hangs));
    tally_and_finish();
  end
endmodule : tb_top

// file: sim/wmt_cpu_model.sv
// Purpose: CPU side model that writes the watchdog registers over AHB-Lite.
// Assumes: Single whole-word transfers, one slave whose hreadyout is hready.
// Notes: Counts waits that ran out in hangs instead of stopping the run.
`timescale 1ns/10ps
module wmt_cpu_model (
  input logic mclk,
  input logic hready,
  output logic hsel,
  output logic [wmt_pkg::ADDR_W-1:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  int hangs;

  // Idle bus from time zero.
  initial begin
    hsel = 1'h0; haddr = '0; htrans = 2'h0; hwrite = 1'h0; hsize = 3'h2; hwdata = '0; hangs = 0;
  end

  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (hready !== 1'h1 && n < 50);
    if (hready !== 1'h1) hangs++;
  endtask : wait_ready

  // Whole-word writes and plain reads are issued, never a read used to modify a value.
  task automatic xfer(input logic [wmt_pkg::ADDR_W-1:0] a, input logic [7:0] d, input logic w);
    @(posedge mclk);
    hsel <= 1'h1; haddr <= a; htrans <= wmt_pkg::HTRANS_NONSEQ; hwrite <= w;
    wait_ready();
    hsel <= 1'h0; htrans <= 2'h0; hwdata <= {24'h0, d};
    wait_ready();
  endtask : xfer
endmodule : wmt_cpu_model

// file: sim/wmt_watchdog_sva.sv
// Purpose: Port-level checker for the watchdog malfunction timer.
// Assumes: One clock domain, synchronous active-high reset.
// Notes: Bound into every wmt_watchdog instance by the statement at the foot.
`timescale 1ns/10ps
module wmt_watchdog_sva #(
  parameter int LF_DIV = 2
) (
  input logic mclk,
  input logic sys_rst,
  input logic hreadyout,
  input logic hresp,
  input logic [31:0] hrdata,
  input logic stop_mode,
  input logic warm_up,
  input logic idle_mode,
  input logic sleep_mode,
  input logic watchdog_reset_request,
  input logic watchdog_interrupt_request,
  input logic trap_area_active,
  input logic trap_action_select
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  // Eight cycles of the reset request; three of them make the full hold time.
  sequence s_hold8;
    watchdog_reset_request [*8];
  endsequence
  property p_rst_len;
    $rose(watchdog_reset_request) |-> s_hold8 ##1 s_hold8 ##1 s_hold8 ##1 !watchdog_reset_request;
  endproperty
  a_rst_len: assert property (p_rst_len) else $error("reset request length wrong");
  property p_irq_pulse;
    watchdog_interrupt_request |=> !watchdog_interrupt_request [*8];
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("interrupt not a pulse");
  property p_never_both;
    !(watchdog_reset_request && watchdog_interrupt_request);
  endproperty
  a_never_both: assert property (p_never_both) else $error("reset and irq together");
  property p_bus_okay;
    hreadyout && hresp == wmt_pkg::HRESP_OKAY;
  endproperty
  a_bus_okay: assert property (p_bus_okay) else $error("bus response not ready okay");
  property p_read_zero;
    hrdata == 32'h0;
  endproperty
  a_read_zero: assert property (p_read_zero) else $error("read data not zero");
  property p_trap_reset;
    $fell(sys_rst) |-> trap_action_select && trap_area_active;
  endproperty
  a_trap_reset: assert property (p_trap_reset) else $error("trap reset values wrong");
  // A freshly reset watchdog cannot have overflowed yet.
  property p_reset_quiet;
    $fell(sys_rst) |-> (!watchdog_reset_request && !watchdog_interrupt_request) [*8];
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("event right after reset");
  // Four frozen cycles leave room for the pipeline between counter and outputs.
  property p_frozen;
    (stop_mode || warm_up || idle_mode || sleep_mode) [*4] |->
      !$rose(watchdog_reset_request) && !watchdog_interrupt_request;
  endproperty
  a_frozen: assert property (p_frozen) else $error("event while frozen");
endmodule : wmt_watchdog_sva

bind wmt_watchdog wmt_watchdog_sva #(.LF_DIV(LF_DIV)) u_sva (
  .mclk(mclk), .sys_rst(sys_rst), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .stop_mode(stop_mode), .warm_up(warm_up), .idle_mode(idle_mode), .sleep_mode(sleep_mode),
  .watchdog_reset_request(watchdog_reset_request),
  .watchdog_interrupt_request(watchdog_interrupt_request),
  .trap_area_active(trap_area_active), .trap_action_select(trap_action_select));

// file: verilog/wmt_counter.sv
// Purpose: Prescale divider and two-stage binary counter of the watchdog.
// Assumes: Control inputs come from logic on mclk.
// Notes: The clear input resets only the binary counter, never the divider.
`timescale 1ns/10ps
module wmt_counter (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic count_en,
  input wire logic hold_clear,
  input wire logic clear_bin,
  input wire logic use_slow,
  input wire logic lf_tick,
  input wire logic [1:0] time_sel,
  output logic overflow
);

  typedef struct packed {
    logic [wmt_pkg::DIV_W-1:0] div;
    logic [1:0] bin;
    logic ovf;
  } wmt_cnt_state_type;

  wmt_cnt_state_type state_reg;
  wmt_cnt_state_type state_next;

  // Mask of the divider bits below the selected tap; a carry reaches the tap
  // when all of them are ones on a counting tick.
  function automatic logic [wmt_pkg::DIV_W-1:0] tap_mask(input logic slow,
                                                         input logic [1:0] sel);
    int tap;
    tap = (slow ? wmt_pkg::SLOW_TAP_BASE : wmt_pkg::FAST_TAP_BASE)
          - wmt_pkg::TAP_STEP * int'(sel);
    tap_mask = wmt_pkg::DIV_W'((64'h1 << tap) - 64'h1);
  endfunction : tap_mask

  // Next-state logic of divider, binary counter and overflow pulse.
  always_comb begin
    logic tick;
    logic tap_hit;
    logic [wmt_pkg::DIV_W-1:0] mask;
    tick = 1'b0;
    tap_hit = 1'b0;
    mask = tap_mask(use_slow, time_sel);
    state_next = state_reg;
    state_next.ovf = 1'b0;
    tick = count_en && (use_slow ? lf_tick : 1'b1); // [RL6] [RL11]
    tap_hit = tick && ((state_reg.div & mask) == mask);
    if (tick) begin
      state_next.div = state_reg.div + 1'b1;
    end
    if (tap_hit) begin
      state_next.bin = state_reg.bin + 1'b1;
      state_next.ovf = (state_reg.bin == 2'h3); // [RL23]
    end
    // A clear code restarts the binary stages only; the divider keeps its phase.
    if (clear_bin) begin
      state_next.bin = 2'h0; // [RL7]
      state_next.ovf = 1'b0;
    end
    if (hold_clear) begin
      state_next.bin = 2'h0; // [RL20]
      state_next.ovf = 1'b0;
    end
  end

  // State register.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign overflow = state_reg.ovf;

endmodule : wmt_counter

// file: verilog/wmt_pkg.sv
// Purpose: Shared constants and types for the watchdog malfunction timer.
// Assumes: One clock, mclk at 10 MHz, which is also the high-frequency clock.
// Notes: Register indices are word indices; the byte address is four times the index.
package wmt_pkg;

  // Bus address width that the slave decodes.
  localparam int ADDR_W = 12;

  // Register indices and their byte addresses on the bus.
  localparam logic [9:0] REG_CTRL_ONE_IDX = 10'h034;
  localparam logic [9:0] REG_CODE_PORT_IDX = 10'h035;
  localparam logic [ADDR_W-1:0] ADDR_CTRL_ONE = {REG_CTRL_ONE_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_CODE_PORT = {REG_CODE_PORT_IDX, 2'h0};

  // Field positions in the first control register.
  localparam int TRAP_AREA_BIT = 5;
  localparam int TRAP_ACTION_BIT = 4;
  localparam int ENABLE_BIT = 3;
  localparam int TIME_HI_BIT = 2;
  localparam int TIME_LO_BIT = 1;
  localparam int OUT_SEL_BIT = 0;
  localparam logic [5:0] CTRL_ONE_RESET = 6'h39;

  // Codes accepted by the code port; any other value does nothing.
  localparam logic [7:0] CODE_CLEAR = 8'h4E;
  localparam logic [7:0] CODE_DISABLE = 8'hB1;
  localparam logic [7:0] CODE_TRAP_AREA = 8'hD2;

  // AHB-Lite encodings used by the slave.
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_BYTE = 3'h0;
  localparam logic [2:0] HSIZE_HALF = 3'h1;
  localparam logic HRESP_OKAY = 1'h0;

  // Prescale divider width and the divider bit that feeds the binary counter.
  // Each tap runs at a quarter of the detection time, so the two-stage counter
  // wraps after four taps.
  localparam int DIV_W = 24;
  localparam int FAST_TAP_BASE = 23;
  localparam int SLOW_TAP_BASE = 15;
  localparam int TAP_STEP = 2;

  // Low-frequency clock made from mclk as an enable pulse.
  localparam int MCLK_FREQ_HZ = 10000000;
  localparam int LF_FREQ_HZ = 32768;
  localparam int LF_DIV_CYCLES = MCLK_FREQ_HZ / LF_FREQ_HZ;
  localparam int LF_CNT_W = 9;

  // Reset request length: the time is 24 high-frequency periods, and the
  // high-frequency clock is mclk, so the cycle count equals the period count.
  localparam int RESET_HOLD_FC_PERIODS = 24;
  localparam int RESET_HOLD_CYCLES = RESET_HOLD_FC_PERIODS * MCLK_FREQ_HZ / MCLK_FREQ_HZ;
  localparam int RST_CNT_W = 5;

  // Run state of the watchdog.
  typedef enum logic [0:0] {
    WMT_STOPPED = 1'b0,
    WMT_RUNNING = 1'b1
  } wmt_run_type;

endpackage : wmt_pkg

// file: verilog/wmt_watchdog.sv
// Purpose: Watchdog malfunction timer with an AHB-Lite register slave.
// Assumes: Mode inputs and the divider source come from logic on mclk.
// Notes: Both registers are write-only; every read returns zero.
`timescale 1ns/10ps

// Contract
// (RL1) Watchdog runs right after reset release without any software action.
// (RL2) After reset, overflow action selects the system reset request.
// (RL3) Overflow action select, once written 0, stays 0 until reset.
// (RL4) Overflow with action select 1 issues a reset request.
// (RL5) Overflow with action select 0 raises the watchdog interrupt request.
// (RL6) Counting freezes in stop, warm-up, idle and sleep; resumes from held count.
// (RL7) Clear code 4EH clears the binary counter only, not the divider.
// (RL8) Software clears within three quarters of the detection time.
// (RL9) First control register is write-only; software avoids read-modify-write.
// (RL10) Control one bit layout 5..0 with reset pattern 11 1001.
// (RL11) Time field selects tap: fast clock 2^25..2^19, slow 2^17..2^11.
// (RL12) Writing enable 0 alone does not stop the watchdog.
// (RL13) Disable code B1H is accepted only while enable bit is 0.
// (RL14) Code port: 4EH clear, B1H disable, D2H trap area, others ignored.
// (RL15) Software never clears the counter from an interrupt task.
// (RL16) Software disables or clears before stop mode and clears after it.
// (RL17) Software programs time and action, clears, then keeps clearing.
// (RL18) With interrupt action it serves as a periodic interrupt timer.
// (RL19) Disable order: master flag off, clear code, enable 0, disable code.
// (RL20) While disabled the binary counters are held cleared.
// (RL21) Watchdog interrupt is non-maskable, ignoring the interrupt master flag.
// (RL22) Watchdog reset request lasts at most 24 high-frequency periods.
// (RL23) Overflow is a one-cycle pulse driving reset or interrupt, never both.
module wmt_watchdog #(
  parameter int LF_DIV = wmt_pkg::LF_DIV_CYCLES
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [wmt_pkg::ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic stop_mode,
  input wire logic warm_up,
  input wire logic idle_mode,
  input wire logic sleep_mode,
  input wire logic low_speed_run_mode,
  input wire logic divider_source_select,
  output logic watchdog_reset_request,
  output logic watchdog_interrupt_request,
  output logic trap_area_active,
  output logic trap_action_select
);

  typedef struct packed {
    logic dp_valid;
    logic dp_write;
    logic dp_lane0;
    logic [wmt_pkg::ADDR_W-1:0] dp_addr;
    logic trap_area_select;
    logic trap_action_select;
    logic watchdog_enable_bit;
    logic [1:0] detection_time_field;
    logic overflow_action_select;
    wmt_pkg::wmt_run_type run;
    logic trap_area_active;
    logic clear_pulse;
    logic [wmt_pkg::LF_CNT_W-1:0] lf_cnt;
    logic lf_tick;
    logic [wmt_pkg::RST_CNT_W-1:0] rst_cnt;
    logic rst_req;
    logic irq;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
  } wmt_state_type;

  wmt_state_type state_reg;
  wmt_state_type state_next;

  logic counter_overflow;
  logic count_en;
  logic use_slow;

  // True when an access of this size and alignment carries byte lane 0, where
  // the 8-bit registers sit.
  function automatic logic lane0_hit(input logic [2:0] size, input logic [1:0] low);
    if (size == wmt_pkg::HSIZE_BYTE) begin
      lane0_hit = (low == 2'h0);
    end else if (size == wmt_pkg::HSIZE_HALF) begin
      lane0_hit = (low[1] == 1'b0);
    end else begin
      lane0_hit = 1'b1;
    end
  endfunction : lane0_hit

  // Counting is gated by the run state and by stop, warm-up, idle and sleep; the held
  // count survives a pause because nothing is cleared here.
  assign count_en = (state_reg.run == wmt_pkg::WMT_RUNNING) &&
                    !(stop_mode || warm_up || idle_mode || sleep_mode); // [RL6]

  // Slow source when the divider is switched to the low-frequency clock or the
  // core runs in low-speed mode.
  assign use_slow = divider_source_select || low_speed_run_mode; // [RL11]

  // Divider and binary counter.
  wmt_counter u_counter (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .count_en(count_en),
    .hold_clear(state_reg.run == wmt_pkg::WMT_STOPPED),
    .clear_bin(state_reg.clear_pulse),
    .use_slow(use_slow),
    .lf_tick(state_reg.lf_tick),
    .time_sel(state_reg.detection_time_field),
    .overflow(counter_overflow)
  );

  // Next-state logic: bus slave, register writes, code port and outputs.
  always_comb begin
    logic wr_now;
    logic [7:0] wbyte;
    wr_now = 1'b0;
    wbyte = 8'h00;
    state_next = state_reg;

    // One-cycle strobes return to zero unless set below.
    state_next.clear_pulse = 1'b0;
    state_next.irq = 1'b0;
    state_next.lf_tick = 1'b0;

    // The slave never inserts wait states and always answers OKAY.
    state_next.hreadyout = 1'b1;
    state_next.hresp = wmt_pkg::HRESP_OKAY;

    // Reads of either register, or of any unmapped address, return zero; the
    // registers hold nothing software could read back reliably anyway.
    state_next.hrdata = 32'h0000_0000; // [RL9]

    // Address phase: capture the request when the bus is ready.
    if (hready) begin
      state_next.dp_valid = hsel && (htrans == wmt_pkg::HTRANS_NONSEQ);
      state_next.dp_write = hwrite;
      state_next.dp_lane0 = lane0_hit(hsize, haddr[1:0]);
      state_next.dp_addr = {haddr[wmt_pkg::ADDR_W-1:2], 2'h0};
    end

    // Data phase: the write data stand now.
    wr_now = state_reg.dp_valid && state_reg.dp_write && state_reg.dp_lane0;
    wbyte = hwdata[7:0];

    // First control register write.
    if (wr_now && (state_reg.dp_addr == wmt_pkg::ADDR_CTRL_ONE)) begin
      state_next.trap_area_select = wbyte[wmt_pkg::TRAP_AREA_BIT]; // [RL10]
      state_next.trap_action_select = wbyte[wmt_pkg::TRAP_ACTION_BIT]; // [RL10]
      state_next.watchdog_enable_bit = wbyte[wmt_pkg::ENABLE_BIT]; // [RL10]
      state_next.detection_time_field =
        wbyte[wmt_pkg::TIME_HI_BIT:wmt_pkg::TIME_LO_BIT]; // [RL10]
      // The action select can only fall; a later 1 cannot bring it back.
      state_next.overflow_action_select =
        state_reg.overflow_action_select && wbyte[wmt_pkg::OUT_SEL_BIT]; // [RL3]
      // Writing enable 1 restarts a stopped watchdog; writing 0 only arms the
      // disable code and leaves the watchdog running.
      if (wbyte[wmt_pkg::ENABLE_BIT]) begin
        state_next.run = wmt_pkg::WMT_RUNNING; // [RL12]
      end
    end

    // Code port write; unknown codes fall through with no effect.
    if (wr_now && (state_reg.dp_addr == wmt_pkg::ADDR_CODE_PORT)) begin
      case (wbyte)
        wmt_pkg::CODE_CLEAR: begin
          state_next.clear_pulse = 1'b1; // [RL7] [RL14]
        end
        wmt_pkg::CODE_DISABLE: begin
          // Honoured only once the enable bit has been written to 0.
          if (!state_reg.watchdog_enable_bit) begin
            state_next.run = wmt_pkg::WMT_STOPPED; // [RL13] [RL14]
          end
        end
        wmt_pkg::CODE_TRAP_AREA: begin
          state_next.trap_area_active = state_reg.trap_area_select; // [RL14]
        end
        default: begin
          state_next.clear_pulse = 1'b0; // [RL14]
        end
      endcase
    end

    // Low-frequency enable pulse made by dividing mclk.
    if (state_reg.lf_cnt >= wmt_pkg::LF_CNT_W'(LF_DIV - 1)) begin
      state_next.lf_cnt = '0;
      state_next.lf_tick = 1'b1;
    end else begin
      state_next.lf_cnt = state_reg.lf_cnt + 1'b1;
    end

    // Reset request stretch; it ends after the fixed hold count.
    if (state_reg.rst_cnt != '0) begin
      state_next.rst_cnt = state_reg.rst_cnt - 1'b1;
      state_next.rst_req = (state_reg.rst_cnt != wmt_pkg::RST_CNT_W'(1)); // [RL22]
    end

    // Each overflow pulse goes to exactly one of the two requests. The
    // interrupt request is not gated by any master flag, so the core must treat
    // it as non-maskable; with the interrupt action this is a periodic timer.
    if (counter_overflow) begin
      if (state_reg.overflow_action_select) begin
        state_next.rst_req = 1'b1; // [RL4] [RL23]
        state_next.rst_cnt = wmt_pkg::RST_CNT_W'(wmt_pkg::RESET_HOLD_CYCLES); // [RL22]
      end else begin
        state_next.irq = 1'b1; // [RL5] [RL18] [RL21] [RL23]
      end
    end
  end

  // State register. Reset brings the watchdog up running, with the reset
  // action selected, so a hung boot is caught without any setup.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_reg <= '0;
      state_reg.trap_area_select <= wmt_pkg::CTRL_ONE_RESET[wmt_pkg::TRAP_AREA_BIT];
      state_reg.trap_action_select <= wmt_pkg::CTRL_ONE_RESET[wmt_pkg::TRAP_ACTION_BIT];
      state_reg.watchdog_enable_bit <= wmt_pkg::CTRL_ONE_RESET[wmt_pkg::ENABLE_BIT]; // [RL1]
      state_reg.detection_time_field <=
        wmt_pkg::CTRL_ONE_RESET[wmt_pkg::TIME_HI_BIT:wmt_pkg::TIME_LO_BIT]; // [RL10]
      state_reg.overflow_action_select <=
        wmt_pkg::CTRL_ONE_RESET[wmt_pkg::OUT_SEL_BIT]; // [RL2]
      state_reg.run <= wmt_pkg::WMT_RUNNING; // [RL1]
      state_reg.trap_area_active <= wmt_pkg::CTRL_ONE_RESET[wmt_pkg::TRAP_AREA_BIT];
      state_reg.hreadyout <= 1'b1;
      state_reg.hresp <= wmt_pkg::HRESP_OKAY;
    end else begin
      state_reg <= state_next;
    end
  end

  // Every output is a field of the state register.
  assign hreadyout = state_reg.hreadyout;
  assign hresp = state_reg.hresp;
  assign hrdata = state_reg.hrdata;
  assign watchdog_reset_request = state_reg.rst_req;
  assign watchdog_interrupt_request = state_reg.irq;
  assign trap_area_active = state_reg.trap_area_active;
  assign trap_action_select = state_reg.trap_action_select;

endmodule : wmt_watchdog
